/* File: common/fbm_pkg.sv */
package fbm_pkg;
  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;

  // ==========================================================
  // timing, in ns, and the derived cycle counts at 40 MHz
  localparam int CLK_PERIOD_NS  = 25;
  localparam int T_READ_NS      = 100; // plain default, adjust per part speed grade
  localparam int T_WE_PULSE_NS  = 75;  // chosen so the pulse is three clocks
  localparam int T_WR_RECOV_NS  = 25;
  localparam int READ_WAIT_CYC  = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_PULSE_CYC   = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_RECOV_CYC   = (T_WR_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W        = 8;

  // ==========================================================
  // command codes the controller itself cares about
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT   = 8'h10;
  localparam logic [7:0] CMD_ERASE      = 8'h20;

  // ==========================================================
  // user request and answer carriers
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fbm_req_t;

  typedef struct packed {
    logic              valid;
    logic              was_write;
    logic [DATA_W-1:0] rdata;
  } fbm_rsp_t;

  // pin strobes, all active low except the level selects
  typedef struct packed {
    logic reset_powerdown_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fbm_strobe_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_PDOWN    = 3'b001,
    ST_WR_SETUP = 3'b010,
    ST_WR_PULSE = 3'b011,
    ST_WR_RECOV = 3'b100,
    ST_RD_WAIT  = 3'b101
  } fbm_state_t;
endpackage

/* File: design/fbm_wait_timer.sv */
`timescale 1ns/1ps
module fbm_wait_timer
  import fbm_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_r;

  // ==========================================================
  // down counter; done while it rests at zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // no dependence on load: the sequencer loads on done, and a
  // path back through load would form a combinational loop
  assign done = (cnt_r == '0);
endmodule

/* File: design/fbm_host.sv */
`timescale 1ns/1ps
module fbm_host
  import fbm_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic              REQ_VALID,
  input  wire fbm_req_t          REQ,
  output logic                   REQ_READY,
  output fbm_rsp_t               RSP,
  input  wire logic              POWERDOWN_REQ,
  input  wire logic              WORD_WIDE,
  input  wire logic              ID_VOLTAGE_REQ,
  input  wire logic              SUPPLY_ON_REQ,
  input  wire logic              BOOT_UNLOCK_REQ,
  output fbm_strobe_t            FL_STROBE,
  output logic [ADDR_W-1:0]      FL_ADDR,
  output logic                   FL_WORD_WIDE,
  output logic                   FL_ID_HIGH_VOLTAGE,
  output logic                   FL_PROGRAM_SUPPLY_ON,
  output logic                   FL_BOOT_UNLOCK_VOLTAGE,
  output logic                   FL_BOOT_PROTECT_OFF,
  input  wire logic [DATA_W-1:0] FL_DQ_I,
  output logic [DATA_W-1:0]      FL_DQ_O,
  output logic [DATA_W-1:0]      FL_DQ_OE
);
  fbm_state_t        state_r, state_nxt;
  fbm_strobe_t       strobe_nxt;
  fbm_req_t          req_r;
  logic              pend_rd_r;
  logic              need_ra_r;
  logic              data_phase_r;
  logic              wide_r;
  logic              tmr_load;
  logic [TIMER_W-1:0] tmr_count;
  logic              tmr_done;
  logic              accept;
  logic              auto_ra;
  logic [DATA_W-1:0] dq_o_nxt;
  logic [DATA_W-1:0] dq_oe_nxt;

  fbm_wait_timer #(.W(TIMER_W)) u_timer (
    .clk   (CLK),
    .rst_b (RST_B),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  assign accept  = (state_r == ST_IDLE) && REQ_READY && REQ_VALID && !POWERDOWN_REQ;
  assign auto_ra = accept && !REQ.write && need_ra_r;

  // ==========================================================
  // sequencer: next state, strobes and timer loads
  always_comb begin
    state_nxt  = state_r;
    strobe_nxt = '{reset_powerdown_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    tmr_load   = 1'b0;
    tmr_count  = '0;
    unique case (state_r)
      ST_IDLE: begin
        if (POWERDOWN_REQ) begin
          state_nxt = ST_PDOWN;
          strobe_nxt.reset_powerdown_n = 1'b0;
        end else if (accept && (REQ.write || auto_ra)) begin
          state_nxt = ST_WR_SETUP;
          strobe_nxt.ce_n = 1'b0;
        end else if (accept) begin
          state_nxt = ST_RD_WAIT;
          strobe_nxt.ce_n = 1'b0;
          strobe_nxt.oe_n = 1'b0;
          tmr_load  = 1'b1;
          tmr_count = TIMER_W'(READ_WAIT_CYC);
        end
      end
      ST_PDOWN: begin
        // hold the part in deep power-down until released
        if (POWERDOWN_REQ) begin
          strobe_nxt.reset_powerdown_n = 1'b0;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        state_nxt = ST_WR_PULSE;
        strobe_nxt.ce_n = 1'b0;
        strobe_nxt.we_n = 1'b0;
        tmr_load  = 1'b1;
        tmr_count = TIMER_W'(WE_PULSE_CYC - 1);
      end
      ST_WR_PULSE: begin
        strobe_nxt.ce_n = 1'b0;
        if (tmr_done) begin
          state_nxt = ST_WR_RECOV; // data latched on the rising write strobe
          tmr_load  = 1'b1;
          tmr_count = TIMER_W'(WR_RECOV_CYC - 1);
        end else begin
          strobe_nxt.we_n = 1'b0;
        end
      end
      ST_WR_RECOV: begin
        if (tmr_done && pend_rd_r) begin
          state_nxt = ST_RD_WAIT; // deferred read after the FFH write
          strobe_nxt.ce_n = 1'b0;
          strobe_nxt.oe_n = 1'b0;
          tmr_load  = 1'b1;
          tmr_count = TIMER_W'(READ_WAIT_CYC);
        end else if (tmr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RD_WAIT: begin
        if (tmr_done) begin
          state_nxt = ST_IDLE;
        end else begin
          strobe_nxt.ce_n = 1'b0;
          strobe_nxt.oe_n = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // data pin drive: only during a write cycle, and in byte mode
  // the top line always carries the lowest address bit
  always_comb begin
    dq_o_nxt  = '0;
    dq_oe_nxt = '0;
    if (state_nxt inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_RECOV}) begin
      // a parked read keeps the read-array code on the lines for the whole write
      dq_o_nxt  = (auto_ra || pend_rd_r) ? DATA_W'(CMD_READ_ARRAY) : (accept ? REQ.wdata : req_r.wdata);
      dq_oe_nxt = wide_r ? '1 : DATA_W'(8'hff);
    end
    if (!wide_r) begin
      dq_o_nxt[DATA_W-1]  = accept ? REQ.addr[0] : req_r.addr[0];
      dq_oe_nxt[DATA_W-1] = 1'b1;
      dq_o_nxt[DATA_W-2:8] = '0;
    end
  end

  // ==========================================================
  // state and pin registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r   <= ST_IDLE;
      FL_STROBE <= '{reset_powerdown_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      FL_DQ_O   <= '0;
      FL_DQ_OE  <= '0;
      FL_ADDR   <= '0;
    end else begin
      state_r   <= state_nxt;
      FL_STROBE <= strobe_nxt;
      FL_DQ_O   <= dq_o_nxt;
      FL_DQ_OE  <= dq_oe_nxt;
      if (accept) begin
        FL_ADDR <= REQ.addr;
      end
    end
  end

  // ==========================================================
  // request capture; a read that needs FFH first is parked
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      req_r     <= '0;
      pend_rd_r <= 1'b0;
    end else if (accept) begin
      req_r     <= REQ;
      pend_rd_r <= auto_ra;
    end else if (state_r == ST_RD_WAIT) begin
      pend_rd_r <= 1'b0;
    end
  end

  // ==========================================================
  // array-mode tracking; the data phase after a setup code is
  // never mistaken for a command, whatever its value, except the FFH
  // write sent for a read in its place, which clears need_ra_r
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      need_ra_r    <= 1'b0;
      data_phase_r <= 1'b0;
    end else if (state_r == ST_PDOWN) begin
      need_ra_r    <= 1'b0;
      data_phase_r <= 1'b0;
    end else if (accept && REQ.write) begin
      data_phase_r <= !data_phase_r && (REQ.wdata[7:0] inside {CMD_PROG_SETUP, CMD_PROG_ALT, CMD_ERASE});
      need_ra_r    <= data_phase_r || (REQ.wdata[7:0] != CMD_READ_ARRAY);
    end else if (auto_ra) begin
      need_ra_r    <= 1'b0;
    end
  end

  // ==========================================================
  // level selects; width is frozen while a cycle is open
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wide_r                 <= 1'b1;
      FL_WORD_WIDE           <= 1'b1;
      FL_ID_HIGH_VOLTAGE     <= 1'b0;
      FL_PROGRAM_SUPPLY_ON   <= 1'b0;
      FL_BOOT_UNLOCK_VOLTAGE <= 1'b0;
      FL_BOOT_PROTECT_OFF    <= 1'b0;
    end else begin
      if (state_r == ST_IDLE && !accept) begin
        wide_r       <= WORD_WIDE;
        FL_WORD_WIDE <= WORD_WIDE;
      end
      FL_ID_HIGH_VOLTAGE     <= ID_VOLTAGE_REQ;
      FL_PROGRAM_SUPPLY_ON   <= SUPPLY_ON_REQ;
      FL_BOOT_UNLOCK_VOLTAGE <= BOOT_UNLOCK_REQ && !POWERDOWN_REQ;
      FL_BOOT_PROTECT_OFF    <= BOOT_UNLOCK_REQ;
    end
  end

  // ==========================================================
  // answer: read data sampled at the end of the access wait
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RSP       <= '0;
      REQ_READY <= 1'b0;
    end else begin
      RSP.valid     <= 1'b0;
      RSP.was_write <= 1'b0;
      REQ_READY     <= (state_nxt == ST_IDLE) && !POWERDOWN_REQ;
      if (state_r == ST_RD_WAIT && tmr_done) begin
        RSP.valid <= 1'b1;
        RSP.rdata <= wide_r ? FL_DQ_I : {8'h00, FL_DQ_I[7:0]};
      end else if (state_r == ST_WR_RECOV && tmr_done && !pend_rd_r) begin
        RSP.valid     <= 1'b1;
        RSP.was_write <= 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_we_pulse;
    FL_STROBE.we_n == 1'b0 [*3] ##1 FL_STROBE.we_n; // three = WE_PULSE_CYC
  endsequence

  chk_read_strobes: assert property (
    !FL_STROBE.oe_n |-> FL_STROBE.we_n && !FL_STROBE.ce_n && FL_STROBE.reset_powerdown_n)
    else $error("read strobes out of order");
  chk_write_strobes: assert property (
    !FL_STROBE.we_n |-> FL_STROBE.oe_n && !FL_STROBE.ce_n && FL_STROBE.reset_powerdown_n && FL_DQ_OE[0])
    else $error("write strobes out of order");
  chk_write_pulse_len: assert property (
    $fell(FL_STROBE.we_n) |-> s_we_pulse)
    else $error("write pulse width wrong");
  chk_read_after_ffh: assert property (
    $fell(FL_STROBE.oe_n) |-> !need_ra_r)
    else $error("read issued without read-array command");
  chk_auto_ffh_data: assert property (
    auto_ra |=> ##1 !FL_STROBE.we_n && FL_DQ_O[7:0] == CMD_READ_ARRAY)
    else $error("read-array code not driven");
  chk_unlock_pdown: assert property (
    !FL_STROBE.reset_powerdown_n |-> !FL_BOOT_UNLOCK_VOLTAGE)
    else $error("unlock voltage raised during power-down");
  chk_pdown_clears_ra: assert property (
    $rose(FL_STROBE.reset_powerdown_n) |-> !need_ra_r)
    else $error("array mode not assumed after power-down");
endmodule

/* File: testbench/fbm_flash_model.sv */
`timescale 1ns/1ps
// ==========================================================
// behavioural flash part seen through its bus pins
module fbm_flash_model
  import fbm_pkg::*;
#(
  parameter int          ACC_NS = 90,
  parameter logic [15:0] MAKER  = 16'h00a5, // arbitrary value
  parameter logic [15:0] DEVICE = 16'h5a3c  // arbitrary value
) (
  input  wire fbm_strobe_t       strobe,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              word_wide,
  input  wire logic              id_hv,
  input  wire logic              supply_on,
  input  wire logic              unlock_hv,
  input  wire logic              protect_off,
  input  wire logic [DATA_W-1:0] dq,
  output logic [DATA_W-1:0]      dq_out,
  output logic [DATA_W-1:0]      dq_en
);
  logic [7:0]        mem [32];
  logic [DATA_W-1:0] lat;
  logic [ADDR_W-1:0] lat_a;
  logic              sel;
  logic              status_r;
  logic              prog_r;
  logic [DATA_W-1:0] rd_val;
  logic [4:0]        lo;
  logic [4:0]        wlo;
  wire logic         rp_n = strobe.reset_powerdown_n;
  wire logic         we_n = strobe.we_n;

  initial foreach (mem[i]) mem[i] = 8'hff;
  // byte mode takes its lowest address from dq15
  assign lo  = {addr[3:0], word_wide ? 1'b0 : dq[15]};
  assign wlo = {lat_a[3:0], word_wide ? 1'b0 : lat[15]};
  // status mode after a program until read array
  always_comb begin
    if (id_hv) rd_val = addr[0] ? DEVICE : MAKER;
    else if (status_r) rd_val = 16'h0080;
    else rd_val = word_wide ? {mem[lo+1], mem[lo]} : {8'h00, mem[lo]};
  end
  // slow access; only a read drives, power-down outranks all
  assign #(ACC_NS) dq_out = rd_val;
  assign #(ACC_NS) dq_en = (rp_n && !strobe.ce_n && !strobe.oe_n && we_n)
    ? (word_wide ? 16'hffff : 16'h00ff) : 16'h0000;
  // sample inside the low phase: data is driven a clock before the strobe drops
  always @(negedge we_n) #10 begin
    lat = dq;
    lat_a = addr;
    sel = !strobe.ce_n;
  end
  // command interface; power-down forces read array
  always @(posedge we_n or negedge rp_n) begin
    if (!rp_n) begin
      status_r <= 1'b0;
      prog_r   <= 1'b0;
    end else if (sel && prog_r) begin
      prog_r   <= 1'b0;
      status_r <= 1'b1;
      if (supply_on && (lat_a >= 17'h02000 || unlock_hv || protect_off)) begin
        if (word_wide) {mem[wlo+1], mem[wlo]} <= lat;
        else mem[wlo] <= lat[7:0];
      end
    end else if (sel) begin
      prog_r <= lat[7:0] == CMD_PROG_SETUP || lat[7:0] == CMD_PROG_ALT;
      if (lat[7:0] == CMD_READ_ARRAY) status_r <= 1'b0;
    end
  end
endmodule

/* File: testbench/fbm_host_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// bench for the flash bus controller
module fbm_host_tb;
  import fbm_pkg::*;
  localparam logic [15:0] MAKER  = 16'h00a5; // arbitrary value
  localparam logic [15:0] DEVICE = 16'h5a3c; // arbitrary value
  fbm_req_t          req;
  fbm_rsp_t          rsp;
  fbm_strobe_t       stb;
  logic              clk, rst_b, vld, rdy, pd, ww, idv, sup, unl;
  logic              f_ww, f_id, f_sup, f_unl, f_wp;
  logic [ADDR_W-1:0] f_a;
  logic [DATA_W-1:0] dq, dq_o, dq_oe, m_dq, m_en, last, v, b1, b2;
  logic [16:0]       q[$];
  int                bad_count, checked, seed;

  fbm_host dut (.CLK(clk), .RST_B(rst_b), .REQ_VALID(vld), .REQ(req), .REQ_READY(rdy), .RSP(rsp),
    .POWERDOWN_REQ(pd), .WORD_WIDE(ww), .ID_VOLTAGE_REQ(idv), .SUPPLY_ON_REQ(sup),
    .BOOT_UNLOCK_REQ(unl), .FL_STROBE(stb), .FL_ADDR(f_a), .FL_WORD_WIDE(f_ww),
    .FL_ID_HIGH_VOLTAGE(f_id), .FL_PROGRAM_SUPPLY_ON(f_sup), .FL_BOOT_UNLOCK_VOLTAGE(f_unl),
    .FL_BOOT_PROTECT_OFF(f_wp), .FL_DQ_I(dq), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe));
  fbm_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) flash (.strobe(stb), .addr(f_a),
    .word_wide(f_ww), .id_hv(f_id), .supply_on(f_sup), .unlock_hv(f_unl), .protect_off(f_wp),
    .dq(dq), .dq_out(m_dq), .dq_en(m_en));

  // undriven lines toggle so a stale value never passes
  assign dq = (dq_oe & dq_o) | (~dq_oe & m_en & m_dq) | (~dq_oe & ~m_en & ~last);
  always @(posedge clk) last <= rst_b ? dq : '0;
  always #12.5 clk = ~clk;

  task automatic check(input string n, input logic [19:0] s, input logic [19:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic results;
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // hold the request until an edge sees ready high
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [DATA_W-1:0] e);
    int n;
    @(posedge clk);
    #2;
    n = 0;
    vld = 1'b1;
    req = '{w, a, d};
    q.push_back({w, w ? 16'h0000 : e});
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    if (rdy !== 1'b1) bad_count++;
    #2 vld = 1'b0;
  endtask

  // setup, data, then read back what should be stored
  task automatic prog(input logic [7:0] c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [DATA_W-1:0] e);
    xfer(1'b1, a, {8'h00, c}, 16'h0);
    xfer(1'b1, a, d, 16'h0);
    xfer(1'b0, a, 16'h0, e);
  endtask

  // level inputs change with nothing in flight, except the supply raise after the first read
  task automatic settle;
    int n;
    n = 0;
    while (q.size() != 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (q.size() != 0) bad_count++;
    step(2);
  endtask

  // oldest note against each answer; pin rules every cycle
  always @(posedge clk) if (rst_b) begin
    if (rsp.valid === 1'b1) check("rsp", 20'({rsp.was_write, rsp.was_write ? 16'h0 : rsp.rdata}), 20'(q.pop_front()));
    if (stb.oe_n === 1'b0) check("read pins", 20'({stb, dq_oe[14:0]}), 20'({4'b1001, 15'h0}));
    if (stb.we_n === 1'b0) check("write pins", 20'(stb), 20'(4'b1010));
    if (f_ww === 1'b0) check("byte lanes", 20'(dq_oe[14:8]), 20'h0);
    if (stb.reset_powerdown_n === 1'b0) check("pdown dq", 20'(dq_oe[14:0]), 20'h0);
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    seed = 60791;
    {clk, rst_b, vld, pd, idv, sup, unl} = '0;
    ww = 1'b1;
    req = '0;
    last = '0;
    step(20);
    rst_b = 1'b1;
    step(2);
    xfer(1'b0, 17'h10005, 16'h0, 16'hffff);
    sup = 1'b1;
    step(2);
    v = 16'($random(seed));
    prog(CMD_PROG_SETUP, 17'h10005, v, v);
    b1 = 16'($random(seed));
    prog(CMD_PROG_ALT, 17'h10006, b1, b1);
    settle();
    sup = 1'b0;
    step(2);
    prog(CMD_PROG_SETUP, 17'h10007, b1, 16'hffff);
    settle();
    sup = 1'b1;
    step(2);
    prog(CMD_PROG_SETUP, 17'h00003, b1, 16'hffff);
    settle();
    unl = 1'b1;
    step(2);
    prog(CMD_PROG_SETUP, 17'h00003, b1, b1);
    xfer(1'b1, 17'h10006, {8'h00, CMD_PROG_SETUP}, 16'h0);
    settle();
    pd = 1'b1;
    step(4);
    check("pdown pin", 20'(stb.reset_powerdown_n), 20'h0);
    pd = 1'b0;
    step(3);
    xfer(1'b0, 17'h10005, 16'h0, v);
    settle();
    idv = 1'b1;
    step(2);
    xfer(1'b0, 17'h0, 16'h0, MAKER);
    xfer(1'b0, 17'h1, 16'h0, DEVICE);
    settle();
    ww = 1'b0;
    step(2);
    xfer(1'b0, 17'h0, 16'h0, {8'h00, MAKER[7:0]});
    settle();
    idv = 1'b0;
    step(2);
    b1 = {8'h00, 8'($random(seed))};
    b2 = {8'h00, 8'($random(seed))};
    prog(CMD_PROG_SETUP, 17'h0000e, b1, b1);
    prog(CMD_PROG_SETUP, 17'h0000f, b2, b2);
    xfer(1'b0, 17'h0000e, 16'h0, b1);
    settle();
    step(5);
    check("queue", 20'(q.size()), 20'h0);
    results();
  end
endmodule
